//--- logic/pgs_top.sv
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
module pgs_chan (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // command from the register block
    input  wire pgs_pkg::pgs_cmd_s cmd,
    input  wire logic [1:0]       step_sel,
    output logic                  busy,
    // strobe pins and shadow gain
    output logic                  raise_n,
    output logic                  lower_n,
    output logic [5:0]            gain
);
    import pgs_pkg::*;

    pgs_state_e st_q;
    pgs_state_e st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       raise_n_q;
    logic       raise_n_d;
    logic       lower_n_q;
    logic       lower_n_d;
    logic [5:0] gain_q;
    logic [5:0] gain_d;

    wire        cmd_any  = cmd.up | cmd.down | cmd.max;
    wire        accept   = cmd_any && (st_q == PGS_IDLE);
    wire        do_max   = cmd.max | (cmd.up & cmd.down);
    wire  [6:0] step_amt = (step_sel == SEL_HALF_DB) ? STEP_HALF_DB :
                           (step_sel == SEL_ONE_DB)  ? STEP_ONE_DB  :
                           (step_sel == SEL_TWO_DB)  ? STEP_TWO_DB  : STEP_SIX_DB;
    wire  [6:0] sum      = {1'b0, gain_q} + step_amt;
    wire  [5:0] gain_up  = (sum > {1'b0, GAIN_MAX}) ? GAIN_MAX : sum[5:0];
    wire  [5:0] gain_down = ({1'b0, gain_q} < step_amt) ? GAIN_MIN
                                                       : 6'(gain_q - step_amt[5:0]);

    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        raise_n_d = raise_n_q;
        lower_n_d = lower_n_q;
        gain_d    = gain_q;
        unique case (st_q)
            PGS_IDLE: begin
                if (accept) begin
                    st_d  = PGS_LOW;
                    cnt_d = 4'(LOW_CYC - 4'h1);
                    if (do_max) begin
                        raise_n_d = 1'b0;
                        lower_n_d = 1'b0;
                        gain_d    = GAIN_MAX;
                    end else if (cmd.up) begin
                        raise_n_d = 1'b0;
                        gain_d    = gain_up;
                    end else begin
                        lower_n_d = 1'b0;
                        gain_d    = gain_down;
                    end
                end
            end
            PGS_LOW: begin
                if (cnt_q == 4'h0) begin
                    st_d      = PGS_REC;
                    cnt_d     = 4'(HIGH_CYC - 4'h1);
                    raise_n_d = 1'b1;
                    lower_n_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            PGS_REC: begin
                if (cnt_q == 4'h0) begin
                    st_d = PGS_IDLE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: begin
                st_d      = PGS_REC;
                cnt_d     = 4'(HIGH_CYC - 4'h1);
                raise_n_d = 1'b1;
                lower_n_d = 1'b1;
            end
        endcase
    end

    // starts in recovery so the first pulse has a full high time before it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q      <= PGS_REC;
            cnt_q     <= 4'(HIGH_CYC - 4'h1);
            raise_n_q <= 1'b1;
            lower_n_q <= 1'b1;
            gain_q    <= GAIN_RESET;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            raise_n_q <= raise_n_d;
            lower_n_q <= lower_n_d;
            gain_q    <= gain_d;
        end
    end

    assign busy    = (st_q != PGS_IDLE);
    assign raise_n = raise_n_q;
    assign lower_n = lower_n_q;
    assign gain    = gain_q;

    // helper counters of strobe run lengths for the timing checks
    logic [3:0] low_len_q;
    logic [3:0] high_len_q;
    wire        any_low = !raise_n_q || !lower_n_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_len_q  <= 4'h0;
            high_len_q <= 4'hF;
        end else begin
            low_len_q  <= any_low ? ((low_len_q == 4'hF) ? low_len_q : low_len_q + 4'h1)
                                  : 4'h0;
            high_len_q <= any_low ? 4'h0
                                  : ((high_len_q == 4'hF) ? high_len_q : high_len_q + 4'h1);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_pulse_start;
        $fell(raise_n_q) || $fell(lower_n_q);
    endsequence
    sequence s_pulse_end;
        $rose(raise_n_q) || $rose(lower_n_q);
    endsequence

    property p_low_min;
        s_pulse_end |-> low_len_q >= LOW_CYC;
    endproperty
    a_low_min: assert property (p_low_min)
        else $error("strobe low time too short");

    property p_high_min;
        s_pulse_start |-> high_len_q >= HIGH_CYC;
    endproperty
    a_high_min: assert property (p_high_min)
        else $error("strobe high time too short");

    property p_max_pair;
        (accept && do_max) |=> (!raise_n_q && !lower_n_q)
                               ##1 (raise_n_q && lower_n_q && gain_q == GAIN_MAX);
    endproperty
    a_max_pair: assert property (p_max_pair)
        else $error("maximum gain pair not issued together");

    property p_six_db;
        (accept && !do_max && cmd.up && step_sel == SEL_SIX_DB && gain_q <= 6'h33)
            |=> gain_q == $past(gain_q) + 6'h0C;
    endproperty
    a_six_db: assert property (p_six_db)
        else $error("six dB step size wrong");

    property p_sat_down;
        (accept && !do_max && cmd.down && gain_q == GAIN_MIN) |=> gain_q == GAIN_MIN;
    endproperty
    a_sat_down: assert property (p_sat_down)
        else $error("gain wrapped below minimum");
endmodule : pgs_chan

module pgs_top (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // device pins
    output logic             mode_select_hi,
    output logic             mode_select_lo,
    output logic [1:0]       step_select,
    output logic             gain_raise_strobe_a_n,
    output logic             gain_lower_strobe_a_n,
    output logic             gain_raise_strobe_b_n,
    output logic             gain_lower_strobe_b_n,
    output logic             chan_a_enable,
    output logic             chan_b_enable
);
    import pgs_pkg::*;

    logic [7:0] dph_addr_q;
    logic       dph_wr_q;
    logic       dph_rd_q;
    logic [3:0] ctrl_q;
    logic [1:0] step_q;
    logic       mode_hi_q;
    logic       mode_lo_q;
    logic       busy_a;
    logic       busy_b;
    logic [5:0] gain_a;
    logic [5:0] gain_b;
    pgs_cmd_s   cmd_a;
    pgs_cmd_s   cmd_b;

    wire        aph_go   = hsel && hready && htrans[1];
    wire        wr_ctrl  = dph_wr_q && (dph_addr_q == OFS_CTRL);
    wire        wr_cmd   = dph_wr_q && (dph_addr_q == OFS_CMD);
    assign cmd_a = wr_cmd ? pgs_cmd_s'(hwdata[CMD_A_LSB +: 3]) : '0;
    assign cmd_b = wr_cmd ? pgs_cmd_s'(hwdata[CMD_B_LSB +: 3]) : '0;
    // step pins move only while no strobe is active or starting
    wire        step_ok  = !busy_a && !busy_b && !wr_cmd;

    wire [31:0] ctrl_rd  = {28'h0000000, ctrl_q};
    wire [31:0] stat_rd  = {6'h00, step_q, 2'h0, gain_b, 2'h0, gain_a, 6'h00, busy_b, busy_a};
    assign hrdata    = !dph_rd_q                 ? 32'h00000000 :
                       (dph_addr_q == OFS_CTRL)   ? ctrl_rd      :
                       (dph_addr_q == OFS_STATUS) ? stat_rd      : 32'h00000000;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_addr_q <= 8'h00;
            dph_wr_q   <= 1'b0;
            dph_rd_q   <= 1'b0;
        end else if (hready) begin
            dph_addr_q <= haddr[7:0];
            dph_wr_q   <= aph_go && hwrite;
            dph_rd_q   <= aph_go && !hwrite;
        end
    end

    // enables reset to the enabled level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= hwdata[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_q <= CTRL_RESET[CTRL_STEP_LSB +: 2];
        end else if (step_ok) begin
            step_q <= ctrl_q[CTRL_STEP_LSB +: 2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_hi_q <= MODE_HI_PULSE;
            mode_lo_q <= MODE_LO_PULSE;
        end else begin
            mode_hi_q <= MODE_HI_PULSE;
            mode_lo_q <= MODE_LO_PULSE;
        end
    end

    pgs_chan u_chan_a (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .cmd      (cmd_a),
        .step_sel (step_q),
        .busy     (busy_a),
        .raise_n  (gain_raise_strobe_a_n),
        .lower_n  (gain_lower_strobe_a_n),
        .gain     (gain_a)
    );

    pgs_chan u_chan_b (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .cmd      (cmd_b),
        .step_sel (step_q),
        .busy     (busy_b),
        .raise_n  (gain_raise_strobe_b_n),
        .lower_n  (gain_lower_strobe_b_n),
        .gain     (gain_b)
    );

    // enables do not touch the gain shadow
    assign chan_a_enable  = ctrl_q[CTRL_EN_A_BIT];
    assign chan_b_enable  = ctrl_q[CTRL_EN_B_BIT];
    assign step_select    = step_q;
    assign mode_select_hi = mode_hi_q;
    assign mode_select_lo = mode_lo_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_mode_pins;
        mode_select_hi == MODE_HI_PULSE && mode_select_lo == MODE_LO_PULSE;
    endproperty
    a_mode_pins: assert property (p_mode_pins)
        else $error("mode pins left pulse setting");

    property p_step_stable;
        (busy_a || busy_b) |-> $stable(step_select);
    endproperty
    a_step_stable: assert property (p_step_stable)
        else $error("step select moved during a pulse");
endmodule : pgs_top

//--- logic/pgs_pkg.sv
// Operation
// - Hold upper mode select low, lower high, during pulse operation.
// - Two step-select outputs, driven by software, stable while pulsing.
// - Strobe must be high 20 ns, then low 20 ns, to count.
// - Both strobes low together 20 ns force maximum gain.
package pgs_pkg;
    // bus clock and strobe timing
    localparam int          CLK_MHZ       = 50;
    localparam int          HIGH_MIN_NS   = 20;
    localparam int          LOW_MIN_NS    = 20;
    localparam int          OVERLAP_NS    = 20;
    localparam int          HIGH_CYC_I    = (HIGH_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int          LOW_CYC_I     = (LOW_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int          OVL_CYC_I     = (OVERLAP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  HIGH_CYC      = HIGH_CYC_I[3:0];
    localparam logic [3:0]  LOW_CYC       = (LOW_CYC_I > OVL_CYC_I) ? LOW_CYC_I[3:0]
                                                                   : OVL_CYC_I[3:0];
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_CMD       = 8'h04;
    localparam logic [7:0]  OFS_STATUS    = 8'h08;
    // ctrl fields and reset
    localparam int          CTRL_STEP_LSB = 0;
    localparam int          CTRL_EN_A_BIT = 2;
    localparam int          CTRL_EN_B_BIT = 3;
    localparam logic [3:0]  CTRL_RESET    = 4'hC;
    // cmd fields: channel a in bits 2:0, channel b in bits 6:4
    localparam int          CMD_A_LSB     = 0;
    localparam int          CMD_B_LSB     = 4;
    // status fields
    localparam int          ST_BUSY_A_BIT = 0;
    localparam int          ST_BUSY_B_BIT = 1;
    localparam int          ST_GAIN_A_LSB = 8;
    localparam int          ST_GAIN_B_LSB = 16;
    localparam int          ST_STEP_LSB   = 24;
    // step select encoding and size in half-dB units
    localparam logic [1:0]  SEL_HALF_DB   = 2'h0;
    localparam logic [1:0]  SEL_ONE_DB    = 2'h1;
    localparam logic [1:0]  SEL_TWO_DB    = 2'h2;
    localparam logic [1:0]  SEL_SIX_DB    = 2'h3;
    localparam logic [6:0]  STEP_HALF_DB  = 7'h01;
    localparam logic [6:0]  STEP_ONE_DB   = 7'h02;
    localparam logic [6:0]  STEP_TWO_DB   = 7'h04;
    localparam logic [6:0]  STEP_SIX_DB   = 7'h0C;
    // gain code limits and reset
    localparam logic [5:0]  GAIN_MAX      = 6'h3F;
    localparam logic [5:0]  GAIN_MIN      = 6'h00;
    localparam logic [5:0]  GAIN_RESET    = 6'h3F;
    // pulse mode pin levels
    localparam logic        MODE_HI_PULSE = 1'b0;
    localparam logic        MODE_LO_PULSE = 1'b1;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic max;
        logic down;
        logic up;
    } pgs_cmd_s;

    typedef enum logic [1:0] {
        PGS_IDLE = 2'h0,
        PGS_LOW  = 2'h1,
        PGS_REC  = 2'h3
    } pgs_state_e;
endpackage : pgs_pkg

//--- dv/pgs_dev_chan.sv
module pgs_dev_chan #(
    // power-up gain of the part is unknown; value arbitrary
    parameter logic [5:0] GAIN_INIT = 6'h15,
    parameter real        HIGH_NS   = 20.0,
    parameter real        LOW_NS    = 20.0,
    parameter real        OVL_NS    = 20.0
) (
    // mode and step pins
    input  wire logic       mode_select_hi,
    input  wire logic       mode_select_lo,
    input  wire logic [1:0] step_select,
    // strobes and enable
    input  wire logic       raise_n,
    input  wire logic       lower_n,
    input  wire logic       enable,
    // state seen by the bench
    output logic [5:0]      gain,
    output logic            active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic    up_p = 1'b1, low_p = 1'b1, up_ok, low_ok, ovl = 1'b0;
    // skip flags start clear so a first plain pulse is not lost
    logic    skip_u = 1'b0, skip_l = 1'b0;
    realtime t_uf = 0.0, t_ur = 0.0, t_lf = 0.0, t_lr = 0.0, t_ov = 0.0;
    wire logic pulse_mode = (mode_select_hi === 1'b0) && (mode_select_lo === 1'b1);
    // floating enable reads high; gain kept whatever the enable
    assign active = (enable !== 1'b0);
    initial gain = GAIN_INIT;

    function automatic logic [5:0] nudge(input logic [5:0] g, input logic up);
        int s, w;
        s = (step_select == 2'h3) ? 12 : (1 << step_select);
        w = up ? g + s : g - s;
        nudge = (w > 63) ? 6'h3F : (w < 0) ? 6'h00 : w[5:0];
    endfunction : nudge

    // qualify each strobe on its own pair only
    always @(raise_n or lower_n) begin
        if (!$isunknown(raise_n) && raise_n !== up_p) begin
            if (!raise_n) begin
                up_ok = ($realtime - t_ur >= HIGH_NS);
                t_uf  = $realtime;
            end else begin
                if (pulse_mode && up_ok && !skip_u && ($realtime - t_uf >= LOW_NS))
                    gain = nudge(gain, 1'b1);
                skip_u = 1'b0;
                t_ur   = $realtime;
            end
            up_p = raise_n;
        end
        if (!$isunknown(lower_n) && lower_n !== low_p) begin
            if (!lower_n) begin
                low_ok = ($realtime - t_lr >= HIGH_NS);
                t_lf   = $realtime;
            end else begin
                if (pulse_mode && low_ok && !skip_l && ($realtime - t_lf >= LOW_NS))
                    gain = nudge(gain, 1'b0);
                skip_l = 1'b0;
                t_lr   = $realtime;
            end
            low_p = lower_n;
        end
        // overlapping strobes never step, even if released one at a time
        if (raise_n === 1'b0 && lower_n === 1'b0 && !ovl) begin
            ovl    = 1'b1;
            t_ov   = $realtime;
            skip_u = 1'b1;
            skip_l = 1'b1;
        end
        if (ovl && (raise_n || lower_n)) begin
            ovl = 1'b0;
            if (pulse_mode && ($realtime - t_ov >= OVL_NS))
                gain = 6'h3F;
        end
    end
endmodule : pgs_dev_chan

//--- dv/test_pulse_gain_stepper.sv
module test_pulse_gain_stepper;
    timeunit 1ns;
    timeprecision 1ps;
    import pgs_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, step_select, sel = 2'h0;
    logic        hreadyout, hresp, mode_select_hi, mode_select_lo;
    logic        gain_raise_strobe_a_n, gain_lower_strobe_a_n, chan_a_enable, act_a;
    logic        gain_raise_strobe_b_n, gain_lower_strobe_b_n, chan_b_enable, act_b;
    logic [5:0]  gain_a, gain_b, exp_a = 6'h3F, exp_b = 6'h3F;
    logic [31:0] rd;
    int          n_fail = 0, checks = 0;

    pgs_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .mode_select_hi(mode_select_hi), .mode_select_lo(mode_select_lo),
        .step_select(step_select), .gain_raise_strobe_a_n(gain_raise_strobe_a_n),
        .gain_lower_strobe_a_n(gain_lower_strobe_a_n),
        .gain_raise_strobe_b_n(gain_raise_strobe_b_n),
        .gain_lower_strobe_b_n(gain_lower_strobe_b_n),
        .chan_a_enable(chan_a_enable), .chan_b_enable(chan_b_enable));
    pgs_dev_chan u_dev_a (.mode_select_hi(mode_select_hi), .mode_select_lo(mode_select_lo),
        .step_select(step_select), .raise_n(gain_raise_strobe_a_n),
        .lower_n(gain_lower_strobe_a_n), .enable(chan_a_enable), .gain(gain_a), .active(act_a));
    pgs_dev_chan u_dev_b (.mode_select_hi(mode_select_hi), .mode_select_lo(mode_select_lo),
        .step_select(step_select), .raise_n(gain_raise_strobe_b_n),
        .lower_n(gain_lower_strobe_b_n), .enable(chan_b_enable), .gain(gain_b), .active(act_b));

    initial forever #10 hclk = ~hclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // address phase held until hready, then data phase until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0, rd);
            n++;
        end while (rd[1:0] !== 2'b00 && n < 20);
        chk("busy", 32'h0, {30'h0, rd[1:0]});
    endtask : wait_idle

    function automatic logic [5:0] upd(input logic [5:0] g, input logic [2:0] c);
        int s, w;
        s = (sel == 2'h3) ? 12 : (1 << sel);
        w = g;
        if (c[2] || c[1:0] == 2'b11) w = 63;
        else if (c[0]) w = g + s;
        else if (c[1]) w = g - s;
        upd = (w > 63) ? 6'h3F : (w < 0) ? 6'h00 : w[5:0];
    endfunction : upd

    task automatic chk_gain();
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        chk("gain_a", {26'h0, exp_a}, {26'h0, gain_a});
        chk("gain_b", {26'h0, exp_b}, {26'h0, gain_b});
        chk("shadow", {20'h0, exp_b, exp_a}, {20'h0, rd[21:16], rd[13:8]});
    endtask : chk_gain

    task automatic pulse(input logic [6:0] c);
        bus(1'b1, OFS_CMD, {25'h0, c}, rd);
        exp_a = upd(exp_a, c[2:0]);
        exp_b = upd(exp_b, c[6:4]);
        wait_idle();
        chk_gain();
    endtask : pulse

    task automatic set_ctrl(input logic [3:0] v);
        bus(1'b1, OFS_CTRL, {28'h0, v}, rd);
        bus(1'b0, OFS_CTRL, 32'h0, rd);
        chk("ctrl", {28'h0, v}, {28'h0, rd[3:0]});
        sel = v[1:0];
        wait_idle();
        chk("applied", {30'h0, v[1:0]}, {30'h0, rd[25:24]});
        chk("pins", {28'h0, v}, {28'h0, chan_b_enable, chan_a_enable, step_select});
        chk("active", {30'h0, v[3:2]}, {30'h0, act_b, act_a});
    endtask : set_ctrl

    initial begin
        #1_000_000;
        n_fail++;
        $display("unexpected watchdog: expected done seen running");
        end_sim();
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("mode", 32'h1, {30'h0, mode_select_hi, mode_select_lo});
        chk("strobes", 32'hF, {28'h0, gain_raise_strobe_a_n, gain_lower_strobe_a_n,
            gain_raise_strobe_b_n, gain_lower_strobe_b_n});
        chk("rst_pins", {28'h0, CTRL_RESET},
            {28'h0, chan_b_enable, chan_a_enable, step_select});
        wait_idle();
        bus(1'b0, OFS_CTRL, 32'h0, rd);
        chk("ctrl_rst", {28'h0, CTRL_RESET}, rd);
        bus(1'b0, 8'h0C, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        pulse(7'h44);
        for (int i = 0; i < 4; i++) begin
            set_ctrl({2'b11, i[1:0]});
            pulse(7'h02);
            pulse(7'h10);
        end
        for (int i = 0; i < 6; i++) pulse(7'h02);
        for (int i = 0; i < 6; i++) pulse(7'h21);
        pulse(7'h03);
        pulse(7'h40);
        pulse(7'h22);
        // a command written while the channel still pulses is dropped
        bus(1'b1, OFS_CMD, 32'h00000002, rd);
        bus(1'b1, OFS_CMD, 32'h00000002, rd);
        exp_a = upd(exp_a, 3'h2);
        wait_idle();
        chk_gain();
        set_ctrl(4'hB);
        pulse(7'h20);
        set_ctrl(4'h7);
        set_ctrl(4'hF);
        chk_gain();
        chk("mode", 32'h1, {30'h0, mode_select_hi, mode_select_lo});
        end_sim();
    end
endmodule : test_pulse_gain_stepper
